//--- design/clmr_core.sv
/*
  clmr_core: executes the or, move, rotate, no-op and return instructions.
  assumes an instruction strobe with one word, a file bank held here,
  a stack top supplied from outside, and an AXI4-Lite slave for inspection.
*/
`timescale 1ns/1ps
`default_nettype none
// Function
// - literal-or ors immediate into work register, only zero flag changes
// - literal-load puts immediate in work register, flags untouched
// - register-or ors work with file register to destination, sets zero
// - destination bit 0 writes work register, 1 writes file register
// - store-work copies work into file register 0..127, flags untouched
// - move-file copies file to destination, zero flag from moved value
// - interrupt-return loads pc from stack top and sets interrupt enable
// - rotate-left shifts file left through carry, only carry changes
// - return-with-literal loads work with immediate and pops stack into pc
// - return-with-literal takes two instruction cycles
module clmr_core
    import clmr_pkg::*;
#(
    parameter int FILE_DEPTH = 128
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [CLMR_IW-1:0] instr_word,
    output logic instr_ready,
    input wire logic [CLMR_PC_W-1:0] stack_top_entry,
    output logic stack_pop,
    output logic [CLMR_PC_W-1:0] pc_out,
    output logic [7:0] work_out,
    output logic zero_flag,
    output logic carry_flag,
    output logic global_interrupt_enable,
    input wire logic [CLMR_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [CLMR_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [1:0] {
        CLMR_EXEC = 2'b01,
        CLMR_FLUSH = 2'b10
    } clmr_state_t;

    logic [7:0] file_q [FILE_DEPTH];
    logic [7:0] w_q, w_d;
    logic z_q, z_d, c_q, c_d, ie_q, ie_d;
    logic [CLMR_PC_W-1:0] pc_q, pc_d;
    logic [15:0] cnt_q, cnt_d;
    clmr_state_t st_q, st_d;
    logic f_we;
    logic [7:0] f_wd;
    logic pop;
    logic [CLMR_FA_W-1:0] fa;
    logic [7:0] fv, lit, res;
    logic dbit, go;
    logic sw_w_we, sw_st_we;
    logic aw_q, aw_d, wd_q, wd_d, bv_q, bv_d, rv_q, rv_d;
    logic [3:0] awa_q, awa_d;
    logic [31:0] wdat_q, wdat_d, rdat_q, rdat_d;

    // instruction fields
    assign fa = instr_word[CLMR_FA_W-1:0];
    assign lit = instr_word[7:0];
    assign dbit = instr_word[CLMR_DBIT];
    assign fv = file_q[fa];
    assign instr_ready = (st_q == CLMR_EXEC);
    assign go = instr_valid && instr_ready;

    // execute: next work, flags, pc, state and file write
    always_comb begin
        w_d = w_q;
        z_d = z_q;
        c_d = c_q;
        ie_d = ie_q;
        pc_d = pc_q;
        cnt_d = cnt_q;
        st_d = st_q;
        f_we = 1'b0;
        f_wd = 8'h00;
        pop = 1'b0;
        res = 8'h00;
        case (st_q)
            CLMR_EXEC: begin
                if (go) begin
                    pc_d = pc_q + 13'h0001;
                    cnt_d = cnt_q + 16'h0001;
                    if (instr_word[13:8] == CLMR_OP_OR_LIT) begin
                        w_d = w_q | lit;
                        z_d = ((w_q | lit) == 8'h00);
                    end else if (instr_word[13:10] == CLMR_OP_LOAD_LIT) begin
                        w_d = lit;
                    end else if (instr_word[13:10] == CLMR_OP_RET_LIT) begin
                        w_d = lit;
                        pc_d = stack_top_entry;
                        pop = 1'b1;
                        st_d = CLMR_FLUSH;
                    end else if (instr_word == CLMR_OP_INT_RET) begin
                        pc_d = stack_top_entry;
                        ie_d = 1'b1;
                        pop = 1'b1;
                        st_d = CLMR_FLUSH;
                    end else if (instr_word[13:7] == CLMR_OP_STORE_WORK) begin
                        f_we = 1'b1;
                        f_wd = w_q;
                    end else if (instr_word[13:8] == CLMR_OP_OR_FILE ||
                                 instr_word[13:8] == CLMR_OP_MOVE_FILE ||
                                 instr_word[13:8] == CLMR_OP_ROT_FILE) begin
                        if (instr_word[13:8] == CLMR_OP_OR_FILE) begin
                            res = w_q | fv;
                            z_d = (res == 8'h00);
                        end else if (instr_word[13:8] == CLMR_OP_MOVE_FILE) begin
                            res = fv;
                            z_d = (fv == 8'h00);
                        end else begin
                            res = {fv[6:0], c_q};
                            c_d = fv[7];
                        end
                        if (dbit) begin
                            f_we = 1'b1;
                            f_wd = res;
                        end else begin
                            w_d = res;
                        end
                    end
                end
            end
            CLMR_FLUSH: begin
                st_d = CLMR_EXEC;
            end
            default: begin
                st_d = CLMR_EXEC;
            end
        endcase
        // software writes steer work register and flags when idle
        if (sw_w_we && !go) begin
            w_d = wdat_q[7:0];
        end
        if (sw_st_we && !go) begin
            z_d = wdat_q[CLMR_ST_Z];
            c_d = wdat_q[CLMR_ST_C];
            ie_d = wdat_q[CLMR_ST_IE];
        end
    end

    // core state registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_q <= CLMR_W_RST;
            z_q <= 1'b0;
            c_q <= 1'b0;
            ie_q <= 1'b0;
            pc_q <= CLMR_PC_RST;
            cnt_q <= 16'h0000;
            st_q <= CLMR_EXEC;
        end else begin
            w_q <= w_d;
            z_q <= z_d;
            c_q <= c_d;
            ie_q <= ie_d;
            pc_q <= pc_d;
            cnt_q <= cnt_d;
            st_q <= st_d;
        end
    end

    // file bank, no reset
    always_ff @(posedge core_clk) begin
        if (f_we) begin
            file_q[fa] <= f_wd;
        end
    end

    assign stack_pop = pop;
    assign pc_out = pc_q;
    assign work_out = w_q;
    assign zero_flag = z_q;
    assign carry_flag = c_q;
    assign global_interrupt_enable = ie_q;

    // axi write: latch address and data in either order, then respond
    assign s_axi_awready = !aw_q && !bv_q;
    assign s_axi_wready = !wd_q && !bv_q;
    logic s_axi_wstrb_q0;
    logic strb_q, strb_d;
    assign s_axi_wstrb_q0 = strb_q;
    assign sw_w_we = aw_q && wd_q && !go && (awa_q == CLMR_REG_W) && s_axi_wstrb_q0;
    assign sw_st_we = aw_q && wd_q && !go && (awa_q == CLMR_REG_STAT) && s_axi_wstrb_q0;
    always_comb begin
        aw_d = aw_q;
        wd_d = wd_q;
        bv_d = bv_q;
        awa_d = awa_q;
        wdat_d = wdat_q;
        strb_d = strb_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awa_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wd_d = 1'b1;
            wdat_d = s_axi_wdata;
            strb_d = s_axi_wstrb[0];
        end
        // commit waits while an instruction executes
        if (aw_q && wd_q && !go) begin
            aw_d = 1'b0;
            wd_d = 1'b0;
            bv_d = 1'b1;
        end
        if (bv_q && s_axi_bready) begin
            bv_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_q <= 1'b0;
            wd_q <= 1'b0;
            bv_q <= 1'b0;
            awa_q <= 4'h0;
            wdat_q <= 32'h0000_0000;
            strb_q <= 1'b0;
        end else begin
            aw_q <= aw_d;
            wd_q <= wd_d;
            bv_q <= bv_d;
            awa_q <= awa_d;
            wdat_q <= wdat_d;
            strb_q <= strb_d;
        end
    end
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = 2'b00;

    // axi read: unmapped offsets read zero with okay
    assign s_axi_arready = !rv_q;
    always_comb begin
        rv_d = rv_q;
        rdat_d = rdat_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            if (s_axi_araddr == CLMR_REG_W) begin
                rdat_d = {24'h000000, w_q};
            end else if (s_axi_araddr == CLMR_REG_STAT) begin
                rdat_d = {29'h0, ie_q, c_q, z_q};
            end else if (s_axi_araddr == CLMR_REG_PC) begin
                rdat_d = {19'h0, pc_q};
            end else if (s_axi_araddr == CLMR_REG_CNT) begin
                rdat_d = {16'h0000, cnt_q};
            end else begin
                rdat_d = 32'h0000_0000;
            end
        end else if (rv_q && s_axi_rready) begin
            rv_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rv_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            rv_q <= rv_d;
            rdat_q <= rdat_d;
        end
    end
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata = rdat_q;
    assign s_axi_rresp = 2'b00;

    // checks
    chk_or_lit_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word[13:8] == CLMR_OP_OR_LIT |=> w_q == ($past(w_q) | $past(lit)) && z_q == (w_q == 8'h00))
        else $error("literal or result wrong");
    chk_load_lit_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word[13:10] == CLMR_OP_LOAD_LIT |=> w_q == $past(lit) && $stable(z_q) && $stable(c_q))
        else $error("literal load wrong");
    chk_or_file_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word[13:8] == CLMR_OP_OR_FILE |=> z_q == ($past(res) == 8'h00))
        else $error("file or zero flag wrong");
    chk_dest_work: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && !dbit && instr_word[13:8] == CLMR_OP_MOVE_FILE |=> w_q == $past(fv))
        else $error("destination zero not work");
    chk_store_work: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word[13:7] == CLMR_OP_STORE_WORK |=> file_q[$past(fa)] == $past(w_q) && $stable(z_q))
        else $error("store work wrong");
    chk_rotate_carry: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word[13:8] == CLMR_OP_ROT_FILE |=> c_q == $past(fv[7]) && $stable(z_q))
        else $error("rotate carry wrong");
    chk_int_return: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word == CLMR_OP_INT_RET |=> ie_q && pc_q == $past(stack_top_entry))
        else $error("interrupt return wrong");
    sequence s_ret_lit_taken;
        go && instr_word[13:10] == CLMR_OP_RET_LIT;
    endsequence
    chk_ret_lit_cycles: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ret_lit_taken |=> !instr_ready ##1 instr_ready)
        else $error("literal return not two cycles");
    chk_ret_lit_pop: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_ret_lit_taken |-> stack_pop ##1 w_q == $past(lit) && pc_q == $past(stack_top_entry))
        else $error("literal return wrong");
    chk_nop_pc: assert property (@(posedge core_clk) disable iff (!rst_n)
        go && instr_word == CLMR_OP_NOP |=> pc_q == $past(pc_q) + 13'h0001 && $stable(w_q) && $stable(c_q))
        else $error("no-op changed state");
endmodule : clmr_core
`default_nettype wire

//--- design/clmr_pkg.sv
/*
  clmr_pkg: constants for the logic/move/return execution block.
  assumes a 14-bit instruction word and an 8-bit data path.
*/
`default_nettype none
package clmr_pkg;
    // instruction field layout
    localparam int CLMR_IW = 14;
    localparam int CLMR_FA_W = 7;
    localparam int CLMR_PC_W = 13;
    localparam int CLMR_DBIT = 7;
    // opcode patterns (upper bits of the word)
    localparam logic [5:0] CLMR_OP_OR_FILE = 6'h04; // or_work_with_file
    localparam logic [5:0] CLMR_OP_MOVE_FILE = 6'h08; // move_file_register
    localparam logic [5:0] CLMR_OP_ROT_FILE = 6'h0d; // rotate_left_via_carry
    localparam logic [6:0] CLMR_OP_STORE_WORK = 7'h01; // store_work_to_file (bits 13:7)
    localparam logic [5:0] CLMR_OP_OR_LIT = 6'h38; // or_literal_into_work
    localparam logic [3:0] CLMR_OP_LOAD_LIT = 4'hc; // load_literal_to_work (bits 13:10)
    localparam logic [3:0] CLMR_OP_RET_LIT = 4'hd; // return_with_literal (bits 13:10)
    localparam logic [13:0] CLMR_OP_INT_RET = 14'h0009; // interrupt_return
    localparam logic [13:0] CLMR_OP_NOP = 14'h0000;
    // reset values
    localparam logic [7:0] CLMR_W_RST = 8'h00;
    localparam logic [12:0] CLMR_PC_RST = 13'h0000;
    // register write-back register address space
    localparam int CLMR_AXI_AW = 4;
    localparam logic [3:0] CLMR_REG_W = 4'h0; // work register, rw
    localparam logic [3:0] CLMR_REG_STAT = 4'h4; // flags and gie, rw
    localparam logic [3:0] CLMR_REG_PC = 4'h8; // program counter, ro
    localparam logic [3:0] CLMR_REG_CNT = 4'hc; // retired instructions, ro
    localparam int CLMR_ST_Z = 0;
    localparam int CLMR_ST_C = 1;
    localparam int CLMR_ST_IE = 2;
endpackage : clmr_pkg
`default_nettype wire

//--- testbench/tb_top.sv
/*
  tb_top: self-checking bench for clmr_core, instruction strobe and AXI4-Lite.
  assumes one 125 MHz clock, pc advancing by one per non-return instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import clmr_pkg::*;
;
    logic core_clk, rst_n, instr_valid, instr_ready, stack_pop;
    logic [CLMR_IW-1:0] instr_word;
    logic [CLMR_PC_W-1:0] stack_top_entry, pc_out, pc_e;
    logic [7:0] work_out, w_e;
    logic zero_flag, carry_flag, global_interrupt_enable, z_e, c_e, g_e;
    logic [3:0] awaddr, araddr, wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    int errors, checked, cyc;
    clmr_core #(.FILE_DEPTH(128)) dut_u (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_ready(instr_ready), .stack_top_entry(stack_top_entry),
        .stack_pop(stack_pop), .pc_out(pc_out), .work_out(work_out), .zero_flag(zero_flag),
        .carry_flag(carry_flag), .global_interrupt_enable(global_interrupt_enable),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // clock generation
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    // hang guard
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors = errors + 1;
            test_done();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // offer one instruction, hold until taken, then compare architectural state
    task automatic ex(input logic [13:0] word, input logic ret);
        logic pop;
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_word <= word;
        do @(negedge core_clk); while (instr_ready !== 1'b1);
        pop = stack_pop;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
        chk("stack_pop", pop, ret);
        if (ret) begin
            chk("ready after return", instr_ready, 1'b0);
            pc_e = stack_top_entry;
        end else begin
            pc_e = pc_e + 1'b1;
        end
        chk("work", work_out, w_e);
        chk("zero", zero_flag, z_e);
        chk("carry", carry_flag, c_e);
        chk("int_enable", global_interrupt_enable, g_e);
        chk("pc", pc_out, pc_e);
    endtask : ex
    // axi4-lite write: address and data offered together, each dropped when taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a; wdata <= d; wstrb <= 4'hf;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk("bresp", bresp, 2'h0);
                break;
            end
        end
    endtask : axw
    task automatic axr(input logic [3:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        forever begin
            @(posedge core_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk("rresp", rresp, 2'h0);
                chk("rdata", rdata, exp);
                break;
            end
        end
    endtask : axr
    // main sequence
    initial begin
        errors = 0; checked = 0;
        rst_n = 1'b0; instr_valid = 1'b0; instr_word = 14'h0000; stack_top_entry = 13'h1234;
        awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        w_e = 8'h00; z_e = 1'b0; c_e = 1'b0; g_e = 1'b0; pc_e = 13'h0000;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        w_e = 8'ha5; ex({CLMR_OP_LOAD_LIT, 2'b00, 8'ha5}, 1'b0);
        ex({CLMR_OP_STORE_WORK, 7'h7f}, 1'b0);
        w_e = 8'h00; ex({CLMR_OP_LOAD_LIT, 2'b00, 8'h00}, 1'b0);
        z_e = 1'b1; ex({CLMR_OP_OR_LIT, 8'h00}, 1'b0);
        w_e = 8'h0f; ex({CLMR_OP_LOAD_LIT, 2'b00, 8'h0f}, 1'b0);
        w_e = 8'haf; z_e = 1'b0; ex({CLMR_OP_OR_FILE, 1'b0, 7'h7f}, 1'b0);
        ex({CLMR_OP_OR_FILE, 1'b1, 7'h7f}, 1'b0);
        w_e = 8'h00; ex({CLMR_OP_LOAD_LIT, 2'b00, 8'h00}, 1'b0);
        ex({CLMR_OP_STORE_WORK, 7'h00}, 1'b0);
        z_e = 1'b1; ex({CLMR_OP_MOVE_FILE, 1'b1, 7'h00}, 1'b0);
        w_e = 8'haf; z_e = 1'b0; ex({CLMR_OP_MOVE_FILE, 1'b0, 7'h7f}, 1'b0);
        w_e = 8'h5e; c_e = 1'b1; ex({CLMR_OP_ROT_FILE, 1'b0, 7'h7f}, 1'b0);
        ex({CLMR_OP_ROT_FILE, 1'b1, 7'h7f}, 1'b0);
        w_e = 8'h5f; ex({CLMR_OP_MOVE_FILE, 1'b0, 7'h7f}, 1'b0);
        w_e = 8'h5f; ex({CLMR_OP_OR_LIT, 8'h50}, 1'b0);
        g_e = 1'b1; ex(CLMR_OP_INT_RET, 1'b1);
        stack_top_entry <= 13'h0abc;
        w_e = 8'h3c; ex({CLMR_OP_RET_LIT, 2'b00, 8'h3c}, 1'b1);
        ex(CLMR_OP_NOP, 1'b0);
        // software access to the inspection registers; eighteen instructions retired so far
        axr(CLMR_REG_CNT, 32'h0000_0012);
        axr(CLMR_REG_STAT, 32'h0000_0006);
        axr(CLMR_REG_PC, {19'h0, pc_e});
        axw(CLMR_REG_W, 32'h0000_0077);
        axr(CLMR_REG_W, 32'h0000_0077);
        axw(CLMR_REG_STAT, 32'h0000_0000);
        axr(CLMR_REG_STAT, 32'h0000_0000);
        axw(CLMR_REG_PC, 32'h0000_0055);
        axr(CLMR_REG_PC, {19'h0, pc_e});
        w_e = 8'h77; z_e = 1'b0; c_e = 1'b0; g_e = 1'b0;
        ex({CLMR_OP_STORE_WORK, 7'h01}, 1'b0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
